//--- ssrl_status_service_request.v
// status register sets, queues summary and service request logic
`timescale 1ns/1ps
`include "ssrl_defines.vh"

// Summary of operation
// - condition registers follow live state, never latched, read only.
// - operation condition measuring bit high while a measurement runs.
// - event bit set by its condition bit, held until cleared.
// - event ANDed with enable, ORed, summary fed into status byte.
// - reading an event register clears it; reset or clear-status clears all.
// - zero enable bit blocks its event; set bit passes it.
// - reading enable leaves it; reset clears all enables.
// - preset clears operation, questionable, measurement enables; zero write clears standard.
// - standard set via event query and enable; others via subsystem commands.
// - message-available set while output queue holds data.
// - error queue first-in first-out, ten messages deep.
// - error-available while error queue nonempty; read pops one.
// - status byte and service request mask, both eight bits.
// - summary bits follow their inputs combinationally, no latching.
// - status byte query shows master summary in bit 6, clears nothing.
// - master summary is OR of summary bits ANDed with mask.
// - enabled summary rising edge sets request bit and service request.
// - serial poll returns byte with request bit, then clears it.
// - new rising edge after poll raises another request.
// - reset clears status byte bits; clear-status clears all but message-available.
// - service mask written by command, read by query, clears on reset.
// - four register sets feed the status byte directly.
// - request stays until polled, cleared by clear-status, or all causes have gone.
// - interface clear leaves settings and event registers unchanged.
module ssrl_status_service_request (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire [15:0] OPER_COND,
  input  wire [15:0] QUES_COND,
  input  wire [15:0] MEAS_COND,
  input  wire [7:0]  STD_COND,
  input  wire        MEAS_BUSY,
  input  wire        CLEAR_STATUS,
  input  wire        STATUS_PRESET,
  input  wire        IFC,
  input  wire [1:0]  SET_SEL,
  input  wire        EVENT_READ,
  input  wire        ENABLE_WRITE,
  input  wire [15:0] ENABLE_WDATA,
  output reg  [15:0] COND_RDATA,
  output reg  [15:0] EVENT_RDATA,
  output reg  [15:0] ENABLE_RDATA,
  input  wire        OUTQ_NOT_EMPTY,
  input  wire        ERR_PUSH,
  input  wire [7:0]  ERR_CODE,
  input  wire        ERR_POP,
  output reg  [7:0]  ERR_RDATA,
  output wire        ERR_FULL,
  input  wire        MASK_WRITE,
  input  wire [7:0]  MASK_WDATA,
  output reg  [7:0]  MASK_RDATA,
  input  wire        STB_QUERY,
  output reg  [7:0]  STB_RDATA,
  input  wire        SERIAL_POLL,
  output reg  [7:0]  POLL_RDATA,
  output wire        SRQ_N_OUT,
  output wire        SRQ_N_OE
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; IFC deliberately goes nowhere
  reg [15:0] oper_s1_q, oper_s2_q, ques_s1_q, ques_s2_q, meas_s1_q, meas_s2_q;
  reg [7:0]  std_s1_q, std_s2_q;
  reg        busy_s1_q, busy_s2_q, mav_s1_q, mav_s2_q;

  always @(posedge CLK) begin
    if (!RST_N) begin
      oper_s1_q <= `SSRL_ZERO16;
      oper_s2_q <= `SSRL_ZERO16;
      ques_s1_q <= `SSRL_ZERO16;
      ques_s2_q <= `SSRL_ZERO16;
      meas_s1_q <= `SSRL_ZERO16;
      meas_s2_q <= `SSRL_ZERO16;
      std_s1_q  <= `SSRL_ZERO8;
      std_s2_q  <= `SSRL_ZERO8;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      mav_s1_q  <= 1'b0;
      mav_s2_q  <= 1'b0;
    end else begin
      oper_s1_q <= OPER_COND;
      oper_s2_q <= oper_s1_q;
      ques_s1_q <= QUES_COND;
      ques_s2_q <= ques_s1_q;
      meas_s1_q <= MEAS_COND;
      meas_s2_q <= meas_s1_q;
      std_s1_q  <= STD_COND;
      std_s2_q  <= std_s1_q;
      busy_s1_q <= MEAS_BUSY;
      busy_s2_q <= busy_s1_q;
      mav_s1_q  <= OUTQ_NOT_EMPTY;
      mav_s2_q  <= mav_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // condition registers
  reg [15:0] oper_cond;
  always @* begin
    oper_cond = oper_s2_q;
    oper_cond[`SSRL_BIT_MEAS] = busy_s2_q;
  end

  function [15:0] sel4;
    input [1:0]  s;
    input [15:0] a, b, c, d;
    begin
      case (s)
        `SSRL_SET_OPER: sel4 = a;
        `SSRL_SET_QUES: sel4 = b;
        `SSRL_SET_MEAS: sel4 = c;
        default:        sel4 = d;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // event and enable registers
  reg [15:0] oper_ev_q, ques_ev_q, meas_ev_q, oper_en_q, ques_en_q, meas_en_q;
  reg [7:0]  std_ev_q, std_en_q;
  wire rd_o = EVENT_READ && (SET_SEL == `SSRL_SET_OPER);
  wire rd_q = EVENT_READ && (SET_SEL == `SSRL_SET_QUES);
  wire rd_m = EVENT_READ && (SET_SEL == `SSRL_SET_MEAS);
  wire rd_s = EVENT_READ && (SET_SEL == `SSRL_SET_STD);
  wire wr_o = ENABLE_WRITE && (SET_SEL == `SSRL_SET_OPER);
  wire wr_q = ENABLE_WRITE && (SET_SEL == `SSRL_SET_QUES);
  wire wr_m = ENABLE_WRITE && (SET_SEL == `SSRL_SET_MEAS);
  wire wr_s = ENABLE_WRITE && (SET_SEL == `SSRL_SET_STD);

  always @(posedge CLK) begin
    if (!RST_N) begin
      oper_ev_q <= `SSRL_ZERO16;
      ques_ev_q <= `SSRL_ZERO16;
      meas_ev_q <= `SSRL_ZERO16;
      std_ev_q  <= `SSRL_ZERO8;
      oper_en_q <= `SSRL_ZERO16;
      ques_en_q <= `SSRL_ZERO16;
      meas_en_q <= `SSRL_ZERO16;
      std_en_q  <= `SSRL_ZERO8;
    end else begin
      oper_ev_q <= ((rd_o || CLEAR_STATUS) ? `SSRL_ZERO16 : oper_ev_q) | oper_cond;
      ques_ev_q <= ((rd_q || CLEAR_STATUS) ? `SSRL_ZERO16 : ques_ev_q) | ques_s2_q;
      meas_ev_q <= ((rd_m || CLEAR_STATUS) ? `SSRL_ZERO16 : meas_ev_q) | meas_s2_q;
      std_ev_q  <= ((rd_s || CLEAR_STATUS) ? `SSRL_ZERO8 : std_ev_q) | std_s2_q;
      if (STATUS_PRESET)
        oper_en_q <= `SSRL_ZERO16;
      else if (wr_o)
        oper_en_q <= ENABLE_WDATA;
      if (STATUS_PRESET)
        ques_en_q <= `SSRL_ZERO16;
      else if (wr_q)
        ques_en_q <= ENABLE_WDATA;
      if (STATUS_PRESET)
        meas_en_q <= `SSRL_ZERO16;
      else if (wr_m)
        meas_en_q <= ENABLE_WDATA;
      if (wr_s)
        std_en_q <= ENABLE_WDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error queue, ten deep
  reg [7:0]             eq_mem [0:9];
  reg [`SSRL_EQ_AW-1:0] eq_wp_q, eq_rp_q, eq_cnt_q;
  wire eq_empty = (eq_cnt_q == 4'd0);
  // full at ten, extra events dropped
  assign ERR_FULL = (eq_cnt_q == `SSRL_EQ_DEPTH);
  wire eq_push = ERR_PUSH && !ERR_FULL;
  wire eq_pop  = ERR_POP && !eq_empty;

  function [`SSRL_EQ_AW-1:0] eq_next;
    input [`SSRL_EQ_AW-1:0] p;
    begin
      eq_next = (p == `SSRL_EQ_DEPTH - 4'd1) ? 4'd0 : p + 4'd1;
    end
  endfunction

  always @(posedge CLK) begin
    if (eq_push)
      eq_mem[eq_wp_q] <= ERR_CODE;
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      eq_wp_q   <= 4'd0;
      eq_rp_q   <= 4'd0;
      eq_cnt_q  <= 4'd0;
      ERR_RDATA <= `SSRL_ZERO8;
    end else begin
      if (eq_push)
        eq_wp_q <= eq_next(eq_wp_q);
      if (eq_pop)
        ERR_RDATA <= eq_mem[eq_rp_q];
      else if (ERR_POP)
        ERR_RDATA <= `SSRL_ZERO8;
      // clear-status empties queue
      // a push in the clearing cycle survives, set wins
      if (CLEAR_STATUS)
        eq_rp_q <= eq_wp_q;
      else if (eq_pop)
        eq_rp_q <= eq_next(eq_rp_q);
      if (CLEAR_STATUS)
        eq_cnt_q <= eq_push ? 4'd1 : 4'd0;
      else if (eq_push && !eq_pop)
        eq_cnt_q <= eq_cnt_q + 4'd1;
      else if (eq_pop && !eq_push)
        eq_cnt_q <= eq_cnt_q - 4'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status byte and service request
  reg [7:0] mask_q;
  reg [7:0] summ;
  reg       rqs_q;
  reg [7:0] prev_en_q;

  always @* begin
    summ = `SSRL_ZERO8;
    summ[`SSRL_BIT_MEAS_SB] = |(meas_ev_q & meas_en_q);
    summ[`SSRL_BIT_QUES]    = |(ques_ev_q & ques_en_q);
    summ[`SSRL_BIT_ESB]     = |(std_ev_q & std_en_q);
    summ[`SSRL_BIT_OPER]    = |(oper_ev_q & oper_en_q);
    summ[`SSRL_BIT_MAV]     = mav_s2_q;
    summ[`SSRL_BIT_EAV]     = !eq_empty;
  end

  wire [7:0] en_summ = summ & mask_q & `SSRL_SUM_MASK;
  wire       mss     = |en_summ;
  // edge relative to previous cycle, not event state
  wire       rise    = |(en_summ & ~prev_en_q);

  always @(posedge CLK) begin
    if (!RST_N) begin
      mask_q    <= `SSRL_ZERO8;
      rqs_q     <= 1'b0;
      prev_en_q <= `SSRL_ZERO8;
    end else begin
      if (MASK_WRITE)
        mask_q <= MASK_WDATA;
      prev_en_q <= en_summ;
      if (rise)
        rqs_q <= 1'b1;
      else if (SERIAL_POLL || CLEAR_STATUS || !mss)
        rqs_q <= 1'b0;
    end
  end

  assign SRQ_N_OUT = 1'b0;
  assign SRQ_N_OE  = !rqs_q;

  ////////////////////////////////////////////////////////////////////////
  // read data, registered
  always @(posedge CLK) begin
    if (!RST_N) begin
      COND_RDATA   <= `SSRL_ZERO16;
      EVENT_RDATA  <= `SSRL_ZERO16;
      ENABLE_RDATA <= `SSRL_ZERO16;
      MASK_RDATA   <= `SSRL_ZERO8;
      STB_RDATA    <= `SSRL_ZERO8;
      POLL_RDATA   <= `SSRL_ZERO8;
    end else begin
      COND_RDATA   <= sel4(SET_SEL, oper_cond, ques_s2_q, meas_s2_q, {8'h00, std_s2_q});
      if (EVENT_READ)
        EVENT_RDATA <= sel4(SET_SEL, oper_ev_q, ques_ev_q, meas_ev_q, {8'h00, std_ev_q});
      ENABLE_RDATA <= sel4(SET_SEL, oper_en_q, ques_en_q, meas_en_q, {8'h00, std_en_q});
      MASK_RDATA   <= mask_q & `SSRL_SUM_MASK;
      if (STB_QUERY)
        STB_RDATA <= (summ & `SSRL_SUM_MASK) | {1'b0, mss, 6'h00};
      if (SERIAL_POLL)
        POLL_RDATA <= (summ & `SSRL_SUM_MASK) | {1'b0, rqs_q, 6'h00};
    end
  end

endmodule // ssrl_status_service_request

//--- ssrl_defines.vh
// constants for the status and service request block
`ifndef SSRL_DEFINES_VH
`define SSRL_DEFINES_VH
`define SSRL_SET_OPER     2'd0
`define SSRL_SET_QUES     2'd1
`define SSRL_SET_MEAS     2'd2
`define SSRL_SET_STD      2'd3
`define SSRL_BIT_MEAS     4
`define SSRL_BIT_MEAS_SB  0
`define SSRL_BIT_EAV      2
`define SSRL_BIT_QUES     3
`define SSRL_BIT_MAV      4
`define SSRL_BIT_ESB      5
`define SSRL_BIT_RQS      6
`define SSRL_BIT_OPER     7
`define SSRL_EQ_DEPTH     4'd10
`define SSRL_EQ_AW        4
`define SSRL_SUM_MASK     8'hbf
`define SSRL_ZERO16       16'h0000
`define SSRL_ZERO8        8'h00
`endif

//--- ssrl_chk.sv
// assertions on the status and service request ports
`timescale 1ns/1ps
module ssrl_chk (
  input wire       CLK,
  input wire       RST_N,
  input wire       CLEAR_STATUS,
  input wire       ERR_PUSH,
  input wire       ERR_POP,
  input wire       ERR_FULL,
  input wire       MASK_WRITE,
  input wire [7:0] MASK_WDATA,
  input wire [7:0] MASK_RDATA,
  input wire       STB_QUERY,
  input wire [7:0] STB_RDATA,
  input wire       SERIAL_POLL,
  input wire [7:0] POLL_RDATA,
  input wire       SRQ_N_OUT,
  input wire       SRQ_N_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_polled;
    SERIAL_POLL ##1 1'b1;
  endsequence
  sequence s_masked;
    MASK_WRITE ##2 1'b1;
  endsequence
  a_stb_holds: assert property (!STB_QUERY |=> $stable(STB_RDATA))
    else $error("status byte moved without query");
  a_stb_mss: assert property (STB_QUERY && !MASK_WRITE |=>
    STB_RDATA[6] == |(STB_RDATA & MASK_RDATA & 8'hbf)) else $error("mss wrong");
  a_poll_rqs: assert property (s_polled |-> POLL_RDATA[6] == !$past(SRQ_N_OE))
    else $error("poll bit 6 wrong");
  a_poll_holds: assert property (!SERIAL_POLL |=> $stable(POLL_RDATA))
    else $error("poll byte moved");
  a_mask_write: assert property (s_masked |-> MASK_RDATA == ($past(MASK_WDATA, 2) & 8'hbf))
    else $error("mask readback wrong");
  a_full_holds: assert property (ERR_FULL && !ERR_POP && !CLEAR_STATUS |=> ERR_FULL)
    else $error("full dropped without pop");
  a_clear_empties: assert property (CLEAR_STATUS && !ERR_PUSH |=> !ERR_FULL)
    else $error("clear-status left queue full");
  a_full_pop: assert property (ERR_FULL && ERR_POP && !ERR_PUSH |=> !ERR_FULL)
    else $error("pop left queue full");
  a_srq_drive: assert property (SRQ_N_OUT == 1'b0)
    else $error("srq drives high");
endmodule // ssrl_chk

//--- ssrl_ctrl_model.sv
// bus controller model: pulled-up service request line and serial polls
`timescale 1ns/1ps
module ssrl_ctrl_model #(
  parameter DELAY = 3
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       srq_n_out,
  input  wire       srq_n_oe,
  input  wire [7:0] poll_rdata,
  input  wire       poll_now,
  input  wire       auto_poll,
  output reg        serial_poll,
  output wire       srq_line,
  output reg  [7:0] poll_byte,
  output reg  [7:0] poll_cnt
);
  reg [3:0] wait_q;
  reg       pend_q;
  assign srq_line = srq_n_oe ? 1'b1 : srq_n_out;
  always @(posedge clk) begin
    if (!rst_n) begin
      wait_q      <= 4'h0;
      pend_q      <= 1'b0;
      serial_poll <= 1'b0;
      poll_byte   <= 8'h00;
      poll_cnt    <= 8'h00;
    end else begin
      // poll on request or at will
      wait_q      <= (auto_poll && !srq_line && !pend_q && !serial_poll) ? wait_q + 4'h1 : 4'h0;
      serial_poll <= poll_now || (wait_q == DELAY);
      pend_q      <= serial_poll;
      if (pend_q) begin
        poll_byte <= poll_rdata;
        poll_cnt  <= poll_cnt + 8'h01;
      end
    end
  end
endmodule // ssrl_ctrl_model

//--- test_status_service_request_logic.sv
// self-checking bench for the status and service request block
`timescale 1ns/1ps
module test_status_service_request_logic;
  reg         clk, rst_n, busy, clr, preset, ifc, ev_rd, en_wr, err_push, err_pop;
  reg         mask_wr, stb_q, outq, poll_now, auto;
  reg  [15:0] oper, en_wd, ques, meas;
  reg  [7:0]  std, err_code, mask_wd;
  reg  [1:0]  sel;
  wire [15:0] cond_rd, ev_rdata, en_rd;
  wire [7:0]  err_rd, mask_rd, stb_rd, poll_rd, poll_byte, poll_cnt;
  wire        err_full, srq_n_out, srq_n_oe, spoll, srq_line;
  integer     n_fail, cmp_count, i;
  ssrl_status_service_request u_dut (
    .CLK(clk), .RST_N(rst_n), .OPER_COND(oper), .QUES_COND(ques), .MEAS_COND(meas),
    .STD_COND(std), .MEAS_BUSY(busy), .CLEAR_STATUS(clr), .STATUS_PRESET(preset), .IFC(ifc),
    .SET_SEL(sel), .EVENT_READ(ev_rd), .ENABLE_WRITE(en_wr), .ENABLE_WDATA(en_wd),
    .COND_RDATA(cond_rd), .EVENT_RDATA(ev_rdata), .ENABLE_RDATA(en_rd), .OUTQ_NOT_EMPTY(outq),
    .ERR_PUSH(err_push), .ERR_CODE(err_code), .ERR_POP(err_pop), .ERR_RDATA(err_rd),
    .ERR_FULL(err_full), .MASK_WRITE(mask_wr), .MASK_WDATA(mask_wd), .MASK_RDATA(mask_rd),
    .STB_QUERY(stb_q), .STB_RDATA(stb_rd), .SERIAL_POLL(spoll), .POLL_RDATA(poll_rd),
    .SRQ_N_OUT(srq_n_out), .SRQ_N_OE(srq_n_oe));
  ssrl_ctrl_model u_ctrl (
    .clk(clk), .rst_n(rst_n), .srq_n_out(srq_n_out), .srq_n_oe(srq_n_oe), .poll_rdata(poll_rd),
    .poll_now(poll_now), .auto_poll(auto), .serial_poll(spoll), .srq_line(srq_line),
    .poll_byte(poll_byte), .poll_cnt(poll_cnt));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task finish_test;
    begin
      if (n_fail == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task bound(input integer n);
    if (n >= 30) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0t wait ran out", $time);
      finish_test;
    end
  endtask
  // strobe k with select and data, result readable on return
  task op(input [3:0] k, input [1:0] s, input [15:0] d);
    begin
      @(posedge clk);
      sel      <= s;
      en_wd    <= d;
      mask_wd  <= d[7:0];
      err_code <= d[7:0];
      case (k)
        4'h0: stb_q <= 1'b1;
        4'h1: ev_rd <= 1'b1;
        4'h2: err_pop <= 1'b1;
        4'h3: mask_wr <= 1'b1;
        4'h4: en_wr <= 1'b1;
        4'h5: clr <= 1'b1;
        4'h6: preset <= 1'b1;
        4'h7: err_push <= 1'b1;
        default: ;
      endcase
      @(posedge clk);
      {stb_q, ev_rd, err_pop, mask_wr, en_wr, clr, preset, err_push} <= 8'h00;
      @(posedge clk);
      #1;
    end
  endtask
  task wait_srq(input lvl);
    begin
      for (i = 0; srq_line !== lvl && i < 30; i = i + 1) begin
        @(posedge clk);
        #1;
      end
      bound(i);
    end
  endtask
  task poll;
    reg [7:0] n0;
    begin
      n0 = poll_cnt;
      @(posedge clk);
      poll_now <= 1'b1;
      @(posedge clk);
      poll_now <= 1'b0;
      for (i = 0; poll_cnt === n0 && i < 30; i = i + 1) begin
        @(posedge clk);
        #1;
      end
      bound(i);
    end
  endtask
  task t_std;
    begin
      op(0, 0, 0); chk(stb_rd, 8'h00);
      chk(srq_line, 1'b1);
      op(3, 0, 16'h0020); chk(mask_rd, 8'h20);
      op(4, 3, 16'h0001);
      @(posedge clk);
      std <= 8'h02;
      repeat (6) @(posedge clk);
      op(0, 0, 0); chk(stb_rd, 8'h00);
      std <= 8'h03;
      wait_srq(1'b0);
      op(0, 0, 0); chk(stb_rd, 8'h60);
      poll; chk(poll_byte, 8'h60);
      chk(srq_line, 1'b1);
      op(0, 0, 0); chk(stb_rd, 8'h60);
      std <= 8'h00;
      repeat (6) @(posedge clk);
      op(1, 3, 0); chk(ev_rdata, 16'h0003);
      op(1, 3, 0); chk(ev_rdata, 16'h0000);
      op(0, 0, 0); chk(stb_rd, 8'h00);
    end
  endtask
  task t_mav;
    begin
      op(3, 0, 16'h0010);
      outq <= 1'b1;
      wait_srq(1'b0);
      poll; chk(poll_byte, 8'h50);
      outq <= 1'b0;
      repeat (4) @(posedge clk);
      op(0, 0, 0); chk(stb_rd, 8'h00);
      auto <= 1'b1;
      outq <= 1'b1;
      wait_srq(1'b0);
      wait_srq(1'b1);
      repeat (2) @(posedge clk);
      #1;
      chk(poll_byte, 8'h50);
      chk(poll_cnt, 8'h03);
      auto <= 1'b0;
    end
  endtask
  task t_err;
    begin
      for (int j = 1; j <= 11; j++) op(7, 0, j[15:0]);
      chk(err_full, 1'b1);
      op(0, 0, 0); chk(stb_rd[2], 1'b1);
      for (int j = 1; j <= 10; j++) begin
        op(2, 0, 0); chk(err_rd, j[7:0]);
      end
      op(2, 0, 0); chk(err_rd, 8'h00);
      outq <= 1'b0;
      // mav passes two flops before the summary
      repeat (2) @(posedge clk);
      op(0, 0, 0); chk(stb_rd, 8'h00);
      op(7, 0, 16'h0001);
      op(5, 0, 0);
      op(0, 0, 0); chk(stb_rd[2], 1'b0);
    end
  endtask
  task t_sets;
    begin
      ques <= 16'h0004;
      meas <= 16'h0008;
      op(4, 1, 16'h0004);
      op(4, 2, 16'h0008);
      op(0, 0, 0); chk(stb_rd, 8'h09);
      op(6, 0, 0);
      op(0, 0, 0); chk(stb_rd, 8'h00);
      op(1, 1, 0); chk(ev_rdata, 16'h0004);
    end
  endtask
  task t_preset;
    begin
      op(4, 0, 16'hffff);
      op(4, 3, 16'h00ff); chk(en_rd, 16'h00ff);
      ifc <= 1'b1;
      op(8, 3, 0); chk(en_rd, 16'h00ff);
      ifc <= 1'b0;
      op(6, 0, 0); chk(en_rd, 16'h0000);
      op(8, 3, 0); chk(en_rd, 16'h00ff);
      op(4, 3, 0); chk(en_rd, 16'h0000);
      busy <= 1'b1;
      op(8, 0, 0); chk(cond_rd[4], 1'b1);
      busy <= 1'b0;
      oper <= 16'h0001;
      op(8, 0, 0); chk(cond_rd[0], 1'b1);
      oper <= 16'h0000;
      // let the cleared condition pass the syncs before clearing
      repeat (2) @(posedge clk);
      op(5, 0, 0);
      op(1, 0, 0); chk(ev_rdata, 16'h0000);
    end
  endtask
  initial begin
    {clk, rst_n, busy, clr, preset, ifc, ev_rd, en_wr, err_push, err_pop} = 10'h000;
    {mask_wr, stb_q, outq, poll_now, auto, oper, en_wd, std, err_code, mask_wd, sel} = 0;
    ques = 16'h0000;
    meas = 16'h0000;
    n_fail = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_std;
    t_mav;
    t_err;
    t_preset;
    t_sets;
    finish_test;
  end
endmodule // test_status_service_request_logic
bind ssrl_status_service_request ssrl_chk u_chk (
  .CLK(CLK), .RST_N(RST_N), .CLEAR_STATUS(CLEAR_STATUS),
  .ERR_PUSH(ERR_PUSH), .ERR_POP(ERR_POP), .ERR_FULL(ERR_FULL),
  .MASK_WRITE(MASK_WRITE), .MASK_WDATA(MASK_WDATA), .MASK_RDATA(MASK_RDATA),
  .STB_QUERY(STB_QUERY), .STB_RDATA(STB_RDATA), .SERIAL_POLL(SERIAL_POLL),
  .POLL_RDATA(POLL_RDATA), .SRQ_N_OUT(SRQ_N_OUT), .SRQ_N_OE(SRQ_N_OE));
